/* File: include/eci_pkg.sv */
// Package of constants and carrier types for the event counter input latch
package eci_pkg;
  // Register offsets on the plain register port (byte addresses)
  localparam logic [7:0] ECI_OFS_CONTROL = 8'h00;
  localparam logic [7:0] ECI_OFS_STATUS = 8'h02;
  localparam logic [7:0] ECI_OFS_IRQ_STATUS = 8'h04;
  localparam logic [7:0] ECI_OFS_IRQ_MASK = 8'h06;
  // Control field positions
  localparam int ECI_POS_EDGE = 7;
  localparam int ECI_POS_RSVD = 3;
  localparam int ECI_POS_CHAN_HI = 2;
  localparam int ECI_POS_CHAN_LO = 0;
  // Reset values
  localparam logic [7:0] ECI_RST_CONTROL = 8'h00;
  localparam logic [7:0] ECI_RST_FLAGS = 8'h00;
  localparam logic [1:0] ECI_RST_IRQ_MASK = 2'h0;
  localparam logic [15:0] ECI_RST_RDATA = 16'h0000;
  // Control bits that software may change
  localparam logic [7:0] ECI_CONTROL_WMASK = 8'h8F;
  // Interrupt status bit positions
  localparam int ECI_IRQ_DETECT = 0;
  localparam int ECI_IRQ_SERVICED = 1;
  localparam int ECI_CHANNELS = 8;

  // Control register contents
  typedef struct packed {
    logic edge_polarity_select;
    logic [2:0] zero_bits;
    logic reserved_rw;
    logic [2:0] channel_count_select;
  } eci_control_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } eci_reg_req_t;

  // Service handshake result toward the transfer controller
  typedef struct packed {
    logic request;
    logic [4:0] addr_code;
  } eci_service_t;
endpackage : eci_pkg

/* File: rtl/eci_event_latch.sv */
// Event input latch: edge detection, pending flags, service request, registers
// What this block does
// - The edge polarity bit picks rising edges at 0 and falling edges at 1, reset 0.
// - Control bits 6 to 4 always read zero and ignore writes.
// - The channel count field enables channels 0 up to its value, 000 one, 111 all eight.
// - A channel whose pin is set as output raises no pending flag.
// - A 16-bit status register holds one pending flag per channel in bits 7 to 0.
// - The transfer controller picks the counter from the registered code, which lags the pending flags by one cycle.
// - A flag reads 1 while its event awaits processing and 0 after, reset 0.
// - The service request follows, one cycle late, whether any pending flag is set.
// - Completing the transfer for a channel clears that channel's flag.
// - The lowest pending channel is serviced first, address code twice its number.
//
// The plain strobed port and the register offsets were decided locally.
module eci_event_latch
  import eci_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] event_inputs,
  input wire logic [7:0] port_pin_direction,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic transfer_done,
  output logic event_service_request,
  output logic [4:0] service_addr_code,
  output logic irq
);

  eci_reg_req_t req;
  eci_control_t event_input_control;
  eci_service_t next_service;
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  logic [7:0] sync_prev;
  logic [7:0] chan_enable;
  logic [7:0] edge_seen;
  logic [7:0] pending_flags;
  logic [7:0] clear_sel;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] irq_event;
  logic [15:0] next_rdata;
  logic [7:0] pin_is_output;
  logic [7:0] rise_seen;
  logic [7:0] fall_seen;
  logic [7:0] lower_pending;
  logic [7:0] service_onehot;
  logic [7:0] next_flags;
  logic [7:0] next_control;
  logic [2:0] service_chan;
  logic [2:0] chan_count;
  logic [1:0] irq_clear;
  logic [1:0] next_irq_status;
  logic [1:0] irq_pending;
  logic [15:0] read_control;
  logic [15:0] read_status;
  logic [15:0] read_irq_status;
  logic [15:0] read_irq_mask;
  logic wr_control;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic edge_falling;
  logic any_detect;
  logic any_serviced;

  // Pin to flag takes three edges: two synchroniser stages, then the history
  // compare. The request and the code follow one edge after the flag, and the
  // interrupt one more edge after its status bit, as both are registered.
  // A pulse shorter than a clock period may be missed; that is the price of
  // sampling the pins rather than clocking on them.

  // Bundle the register port for decode
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Write decode; the status register has no write strobe, so writes to it are lost
  assign wr_control = req.wr && (req.addr == ECI_OFS_CONTROL);
  assign wr_irq_status = req.wr && (req.addr == ECI_OFS_IRQ_STATUS);
  assign wr_irq_mask = req.wr && (req.addr == ECI_OFS_IRQ_MASK);

  // Control fields by name for the channel logic
  assign edge_falling = event_input_control.edge_polarity_select;
  assign chan_count = event_input_control.channel_count_select;

  // Next control value; bits 6..4 are masked off before they can store
  assign next_control = req.wdata[7:0] & ECI_CONTROL_WMASK;

  // Control register; bits 6..4 never store, so they read zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      event_input_control <= ECI_RST_CONTROL;
    end else if (wr_control) begin
      event_input_control <= next_control;
    end
  end

  // Bit 3 is kept as plain storage and reads back as written.
  // It steers nothing here, so a stray one from software changes no behaviour;
  // zero, its reset value, is the one software is expected to keep.

  // First synchroniser stage; only the second stage reads it.
  // The pins count as synchronous, yet two stages cost little and keep a
  // late-settling pin from reaching the edge logic as a half level.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_a <= ECI_RST_FLAGS;
    end else begin
      sync_a <= event_inputs;
    end
  end

  // Second synchroniser stage, the newer sample for the compare
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_b <= ECI_RST_FLAGS;
    end else begin
      sync_b <= sync_a;
    end
  end

  // History stage, the older sample; resets low like an idle pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_prev <= ECI_RST_FLAGS;
    end else begin
      sync_prev <= sync_b;
    end
  end

  // Per channel enable, edge detect, lowest pending and clear select
  genvar gi;
  generate
    for (gi = 0; gi < ECI_CHANNELS; gi++) begin : g_chan
      // Contiguous group from channel 0
      assign chan_enable[gi] = (3'(gi) <= chan_count);
      // A pin the port drives is not an event source
      assign pin_is_output[gi] = port_pin_direction[gi];
      // Rising: older sample low, newer sample high
      assign rise_seen[gi] = !sync_prev[gi] && sync_b[gi];
      // Falling: older sample high, newer sample low
      assign fall_seen[gi] = sync_prev[gi] && !sync_b[gi];
      // Qualified edge of the selected polarity
      assign edge_seen[gi] = chan_enable[gi] && !pin_is_output[gi] &&
        (edge_falling ? fall_seen[gi] : rise_seen[gi]);
      // Any lower channel pending; it outranks this one
      assign lower_pending[gi] = |(pending_flags & ((8'h01 << gi) - 8'h01));
      // One-hot mark of the lowest pending channel
      assign service_onehot[gi] = pending_flags[gi] && !lower_pending[gi];
      // Clear the channel the shown code names, not the lowest at this edge:
      // a lower flag set in the last cycle has not reached the code yet
      assign clear_sel[gi] = transfer_done && event_service_request && pending_flags[gi] &&
        (service_addr_code == 5'(gi * 2));
    end
  endgenerate

  // Next flags: clear first, then a fresh edge sets, so the set wins.
  // Repeat edges on a channel still pending merge into the one flag; a user
  // who needs every edge counted must service faster than the pins toggle.
  always_comb begin
    next_flags = pending_flags & ~clear_sel;
    next_flags = next_flags | edge_seen;
  end

  // Pending flags
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pending_flags <= ECI_RST_FLAGS;
    end else begin
      pending_flags <= next_flags;
    end
  end

  // Lowest pending channel as an index; one-hot input keeps the items exclusive
  always_comb begin
    service_chan = 3'h0;
    case (service_onehot)
      8'h01: service_chan = 3'h0;
      8'h02: service_chan = 3'h1;
      8'h04: service_chan = 3'h2;
      8'h08: service_chan = 3'h3;
      8'h10: service_chan = 3'h4;
      8'h20: service_chan = 3'h5;
      8'h40: service_chan = 3'h6;
      8'h80: service_chan = 3'h7;
      default: service_chan = 3'h0;
    endcase
  end

  // Request and code for the transfer controller; code is twice the channel
  always_comb begin
    next_service.request = |pending_flags;
    next_service.addr_code = {1'b0, service_chan, 1'b0};
  end

  // Request registered; follows the flags one cycle later
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      event_service_request <= 1'b0;
    end else begin
      event_service_request <= next_service.request;
    end
  end

  // Code registered beside the request, so both change on the same edge.
  // The controller acts on this code; the clear above follows it, never
  // the live flags, so a late lower event cannot steal the completion.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      service_addr_code <= 5'h00;
    end else begin
      service_addr_code <= next_service.addr_code;
    end
  end

  // Interrupt events: any detection, any completion
  assign any_detect = |edge_seen;
  assign any_serviced = |clear_sel;
  assign irq_event[ECI_IRQ_DETECT] = any_detect;
  assign irq_event[ECI_IRQ_SERVICED] = any_serviced;

  // Bits to clear: the ones written as one to the interrupt status register
  assign irq_clear = wr_irq_status ? req.wdata[1:0] : 2'h0;

  // Clear first, then set, so an event in the clearing cycle is not lost
  always_comb begin
    next_irq_status = irq_status & ~irq_clear;
    next_irq_status = next_irq_status | irq_event;
  end

  // Sticky status, write one to clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_status <= ECI_RST_IRQ_MASK;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Interrupt mask, one bit per status bit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_mask <= ECI_RST_IRQ_MASK;
    end else if (wr_irq_mask) begin
      irq_mask <= req.wdata[1:0];
    end
  end

  // Unmasked status bits
  assign irq_pending = irq_status & irq_mask;

  // Level interrupt; lags status by one cycle because it is registered
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |irq_pending;
    end
  end

  // Each register as a full word; upper bits are zero filled
  assign read_control = {8'h00, event_input_control};
  assign read_status = {8'h00, pending_flags};
  assign read_irq_status = {14'h0000, irq_status};
  assign read_irq_mask = {14'h0000, irq_mask};

  // Read mux; word-wide only, unmapped addresses read zero
  always_comb begin
    next_rdata = ECI_RST_RDATA;
    case (req.addr)
      ECI_OFS_CONTROL: next_rdata = read_control;
      ECI_OFS_STATUS: next_rdata = read_status;
      ECI_OFS_IRQ_STATUS: next_rdata = read_irq_status;
      ECI_OFS_IRQ_MASK: next_rdata = read_irq_mask;
      default: next_rdata = ECI_RST_RDATA;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= ECI_RST_RDATA;
    end else if (req.rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= ECI_RST_RDATA;
    end
  end

endmodule : eci_event_latch

/* File: dv/eci_properties.sv */
// Port checker for the event latch
module eci_checker
  import eci_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic transfer_done,
  input wire logic event_service_request,
  input wire logic [4:0] service_addr_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_st;
  logic rd_ct;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Which register the current read data answers
  always_ff @(posedge clk) begin
    rd_st <= reg_rd && reg_addr == ECI_OFS_STATUS;
    rd_ct <= reg_rd && reg_addr == ECI_OFS_CONTROL;
  end
  idle_rdata_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("rdata not idle");
  status_upper_a: assert property (rd_st |-> reg_rdata[15:8] == 8'h00)
    else $error("status upper set");
  control_zero_a: assert property (rd_ct |-> reg_rdata[6:4] == 3'h0)
    else $error("control 6..4 set");
  request_flags_a: assert property (rd_st |-> event_service_request == |reg_rdata[7:0])
    else $error("request mismatch");
  lowest_first_a: assert property (rd_st && reg_rdata[0] |-> service_addr_code == 5'h00)
    else $error("code not lowest");
  code_idle_a: assert property (!event_service_request |-> service_addr_code == 5'h00)
    else $error("code while idle");
  code_range_a: assert property (service_addr_code <= 5'h0E && !service_addr_code[0])
    else $error("code out of range");
  // Reset also drops the request, hence the guard
  clear_done_a: assert property ($fell(event_service_request) && $past(rst_b) |->
    $past(transfer_done, 2)) else $error("flag cleared without done");
endmodule : eci_checker

bind eci_event_latch eci_checker chk_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .transfer_done(transfer_done),
  .event_service_request(event_service_request), .service_addr_code(service_addr_code));

/* File: dv/eci_event_src.sv */
// Model of the external event sources
module eci_event_src (
  input wire logic clk,
  input wire logic [7:0] target,
  output logic [7:0] event_inputs = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins follow the wanted levels one edge late, like a slow source
  always @(posedge clk) event_inputs <= target;
endmodule : eci_event_src

/* File: dv/tb.sv */
// Self-checking bench for the event latch
module tb import eci_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] tgt = 8'h00;
  logic [7:0] pins;
  logic [7:0] dir = 8'h00;
  eci_reg_req_t req = '0;
  logic done = 1'b0;
  logic [15:0] rdata;
  logic srq;
  logic [4:0] code;
  logic irq;
  int error_cnt = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  eci_event_src src_u (.clk(clk), .target(tgt), .event_inputs(pins));
  eci_event_latch dut_u (.clk(clk), .rst_b(rst_b), .event_inputs(pins), .port_pin_direction(dir),
    .reg_addr(req.addr), .reg_wdata(req.wdata), .reg_wr(req.wr), .reg_rd(req.rd),
    .reg_rdata(rdata), .transfer_done(done), .event_service_request(srq),
    .service_addr_code(code), .irq(irq));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  // Read data are looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 check("rdata", rdata, exp);
  endtask : rd
  // Service pending channels, lowest first
  task automatic drain(input int n);
    for (int i = 0; i < n; i++) begin
      #1 check("code", {11'h000, code}, 16'(2 * i));
      check("request", {15'h0000, srq}, 16'h0001);
      @(posedge clk) done <= 1'b1;
      @(posedge clk) done <= 1'b0;
      @(posedge clk);
    end
  endtask : drain
  task automatic t_ctrl();
    rd(ECI_OFS_CONTROL, 16'h0000);
    rd(ECI_OFS_STATUS, 16'h0000);
    wr(ECI_OFS_STATUS, 16'h00FF);
    rd(ECI_OFS_STATUS, 16'h0000);
    wr(ECI_OFS_CONTROL, 16'h00F7);
    rd(ECI_OFS_CONTROL, 16'h0087);
    $display("control test done");
  endtask : t_ctrl
  // Pin 7 set as output must stay silent
  task automatic t_rise();
    wr(ECI_OFS_CONTROL, 16'h0007);
    wr(ECI_OFS_IRQ_MASK, 16'h0001);
    dir <= 8'h80;
    tgt <= 8'hFF;
    repeat (6) @(posedge clk);
    rd(ECI_OFS_STATUS, 16'h007F);
    check("irq", {15'h0000, irq}, 16'h0001);
    drain(7);
    rd(ECI_OFS_STATUS, 16'h0000);
    rd(ECI_OFS_IRQ_STATUS, 16'h0003);
    rd(ECI_OFS_IRQ_MASK, 16'h0001);
    wr(ECI_OFS_IRQ_STATUS, 16'h0003);
    repeat (2) @(posedge clk);
    #1 check("irq", {15'h0000, irq}, 16'h0000);
    $display("rising test done");
  endtask : t_rise
  task automatic t_fall();
    wr(ECI_OFS_CONTROL, 16'h0082);
    wr(ECI_OFS_IRQ_MASK, 16'h0000);
    dir <= 8'h00;
    tgt <= 8'h00;
    repeat (6) @(posedge clk);
    rd(ECI_OFS_STATUS, 16'h0007);
    check("irq", {15'h0000, irq}, 16'h0000);
    drain(3);
    $display("falling test done");
  endtask : t_fall
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_ctrl();
    t_rise();
    t_fall();
    complete_run();
  end
  // Watchdog well beyond the roughly eighty cycles needed
  initial begin
    #20000;
    error_cnt++;
    complete_run();
  end
endmodule : tb
